// ===== tw_pkg.sv
// Purpose: Shared constants and types for the two-wire port
// Assumes: 32-bit APB data, registers one aligned word each
// Notes: Register offsets are byte addresses
`default_nettype none
package tw_pkg;
  // ---------------------------------------------
  // Register byte offsets
  // ---------------------------------------------
  localparam logic [7:0] OFS_CON = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MSK = 8'h08;
  localparam logic [7:0] OFS_RCV = 8'h0C;
  localparam logic [7:0] OFS_TRN = 8'h10;
  localparam logic [7:0] OFS_ADD = 8'h14;
  localparam logic [7:0] OFS_BRG = 8'h18;
  // ---------------------------------------------
  // Control bit positions
  // ---------------------------------------------
  localparam int C_ON = 15;
  localparam int C_SIDL = 13;
  localparam int C_REL = 12;
  localparam int C_ALL = 11;
  localparam int C_TEN = 10;
  localparam int C_GENERAL_CALL_ENABLE = 7;
  localparam int C_STR = 6;
  localparam int C_ACKV = 5;
  localparam int C_ACKS = 4;
  localparam int C_MASTER_RECEIVE_ENABLE = 3;
  localparam int C_STOP = 2;
  localparam int C_RSTR = 1;
  localparam int C_STRT = 0;
  // ---------------------------------------------
  // Status bit positions
  // ---------------------------------------------
  localparam int S_ACKST = 15;
  localparam int S_TRST = 14;
  localparam int S_BCL = 10;
  localparam int S_WRITE_COLLISION_FLAG = 7;
  localparam int S_OV = 6;
  // ---------------------------------------------
  // Reset values and counts
  // ---------------------------------------------
  localparam logic [15:0] CON_RST = 16'h1000;
  localparam logic [15:0] CON_WMASK = 16'hBFFF;
  localparam logic [15:0] BRG_RST = 16'h0000;
  localparam logic [9:0] MSK_RST = 10'h000;
  localparam logic [9:0] ADD_RST = 10'h000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] TEN_HDR = 5'h1E;
  // Master and slave sequencer states
  typedef enum logic [2:0] {M_IDLE, M_START, M_RESTART, M_STOP, M_TX, M_RX, M_ACK} tw_mst_t;
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_ADDR2, SL_RX, SL_TX, SL_SKIP} tw_slv_t;
endpackage
`default_nettype wire

// ===== tw_line_if.sv
// Purpose: Filtered line levels and bus events
// Assumes: One clock domain
// Notes: Produced by the line synchroniser
`default_nettype none
interface tw_line_if;
  logic sclLvl; // Filtered clock line
  logic sdaLvl; // Filtered data line
  logic sclRise; // Clock line rose
  logic sclFall; // Clock line fell
  logic startDet; // Start or repeated start seen
  logic stopDet; // Stop seen
  modport src (output sclLvl, sdaLvl, sclRise, sclFall, startDet, stopDet);
  modport dst (input sclLvl, sdaLvl, sclRise, sclFall, startDet, stopDet);
endinterface
`default_nettype wire

// ===== tw_line_sync.sv
// Purpose: Synchronise and filter both bus lines, find conditions
// Assumes: Lines idle high
// Notes: A change counts once second and third stages agree
`default_nettype none
module tw_line_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  tw_line_if.src ln
);
  logic [2:0] sclSh_r; // Three-stage chain
  logic [2:0] sdaSh_r; // Three-stage chain
  logic sclLvl_r; // Accepted level
  logic sdaLvl_r; // Accepted level
  logic sclNxt;
  logic sdaNxt;
  // ---------------------------------------------
  // Synchroniser chains
  // ---------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclSh_r <= 3'h7;
      sdaSh_r <= 3'h7;
    end else begin
      sclSh_r <= {sclSh_r[1:0], sclIn};
      sdaSh_r <= {sdaSh_r[1:0], sdaIn};
    end
  end
  // Accept a level when stages two and three agree
  assign sclNxt = (sclSh_r[1] == sclSh_r[2]) ? sclSh_r[2] : sclLvl_r;
  assign sdaNxt = (sdaSh_r[1] == sdaSh_r[2]) ? sdaSh_r[2] : sdaLvl_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclLvl_r <= 1'b1;
      sdaLvl_r <= 1'b1;
    end else begin
      sclLvl_r <= sclNxt;
      sdaLvl_r <= sdaNxt;
    end
  end
  // ---------------------------------------------
  // Edges and bus conditions
  // ---------------------------------------------
  assign ln.sclLvl = sclLvl_r;
  assign ln.sdaLvl = sdaLvl_r;
  assign ln.sclRise = sclNxt && !sclLvl_r;
  assign ln.sclFall = !sclNxt && sclLvl_r;
  // Data falls while clock high
  assign ln.startDet = sclLvl_r && sclNxt && sdaLvl_r && !sdaNxt;
  // Data rises while clock high
  assign ln.stopDet = sclLvl_r && sclNxt && !sdaLvl_r && sdaNxt;
endmodule // tw_line_sync
`default_nettype wire

// ===== tw_port.sv
// Purpose: Two-wire bus port, master and addressed slave, APB registers
// Assumes: 20 MHz clk, open-drain lines, wait-one APB answer
// Notes: Pins driven low only; output enable high means pull low
//
// The register offsets and the APB slave port were decided locally.
`default_nettype none
module tw_port
  import tw_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic pinsOwned,
  output logic byteEvent
);
  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  tw_line_if ln ();
  logic [15:0] con_r; // Control register
  logic [9:0] mask_r; // Address mask bits
  logic [9:0] own_r; // Own address
  logic [15:0] rateReload_r; // Rate reload
  logic [7:0] rxHold_r; // Receive holding
  logic [7:0] txHold_r; // Transmit holding
  logic rbf_r, tbf_r, ov_r, write_collision_flag_r, bcl_r; // Sticky and full flags
  logic ackSt_r, trSt_r, gc_r, ten_r, da_r; // Status flags
  logic pSeen_r, sSeen_r, rw_r, tenArm_r, mOwn_r;
  logic halfEn_r; // Tcy/2 enable
  logic [15:0] rateCnt_r; // Down counter
  logic rateTick; // Counter reached zero
  tw_mst_t mst_r; // Master sequencer
  logic [1:0] ph_r; // Phase within a step
  logic [3:0] mCnt_r; // Master bit count
  logic [7:0] mSh_r; // Master shifter
  logic mScl_r, mSda_r; // Master pulls low
  logic mEnd, mAbort, mBit, txGo, busy;
  tw_slv_t sst_r; // Slave sequencer
  logic [3:0] sCnt_r; // Slave bit count
  logic [7:0] sSh_r, sTx_r; // Slave shifters
  logic sDrv_r; // Slave pulls data low
  logic rxLoad; // Byte ready for holding
  logic [7:0] rxData;
  logic sAdrHit, sGc, sEnd8, sAckClk;
  logic accWr, accRd;
  logic [2:0] sel;
  logic lineLow_r;
  logic moduleOn;

  // Address compare with mask; set mask bits are ignored
  function automatic logic addrMatch(input logic [9:0] got, input logic [9:0] ref_a,
                                     input logic [9:0] msk);
    return ((got ^ ref_a) & ~msk) == 10'h000;
  endfunction

  // Register select from bus address
  function automatic logic [2:0] regSel(input logic [AW-1:0] a);
    unique case (a[7:0])
      OFS_CON: return 3'h1;
      OFS_STAT: return 3'h2;
      OFS_MSK: return 3'h3;
      OFS_RCV: return 3'h4;
      OFS_TRN: return 3'h5;
      OFS_ADD: return 3'h6;
      OFS_BRG: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  tw_line_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .ln(ln)
  );

  assign moduleOn = con_r[C_ON];
  assign sel = regSel(paddr);
  // ---------------------------------------------
  // APB slave: one wait state, action at completion
  // ---------------------------------------------
  assign accWr = psel && penable && pready && pwrite;
  assign accRd = psel && penable && pready && !pwrite;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= (sel == 3'h0);
      unique case (sel)
        3'h1: prdata <= {16'h0000, con_r};
        3'h2: prdata <= {16'h0000, ackSt_r, trSt_r, 3'b000, bcl_r, gc_r, ten_r,
                         write_collision_flag_r, ov_r, da_r, pSeen_r, sSeen_r, rw_r, rbf_r, tbf_r};
        3'h3: prdata <= {22'h00_0000, mask_r};
        3'h4: prdata <= {24'h00_0000, rxHold_r};
        3'h5: prdata <= {24'h00_0000, txHold_r};
        3'h6: prdata <= {22'h00_0000, own_r};
        3'h7: prdata <= {16'h0000, rateReload_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
  // Plain configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_r <= MSK_RST;
      own_r <= ADD_RST;
      rateReload_r <= BRG_RST;
    end else if (accWr) begin
      if (sel == 3'h3) mask_r <= pwdata[9:0];
      if (sel == 3'h6) own_r <= pwdata[9:0];
      if (sel == 3'h7) rateReload_r <= pwdata[15:0];
    end
  end
  // ---------------------------------------------
  // Control register with hardware clears
  // ---------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      con_r <= CON_RST;
    end else begin
      if (accWr && sel == 3'h1) begin
        con_r <= pwdata[15:0] & CON_WMASK;
        // Writing 0 to release only stretches if allowed
        if (!con_r[C_STR] && !pwdata[C_REL]) con_r[C_REL] <= con_r[C_REL];
      end
      // Self-clearing request bits
      if (mEnd && mst_r == M_START) con_r[C_STRT] <= 1'b0;
      if (mEnd && mst_r == M_RESTART) con_r[C_RSTR] <= 1'b0;
      if (mEnd && mst_r == M_STOP) con_r[C_STOP] <= 1'b0;
      if (mEnd && mst_r == M_RX) con_r[C_MASTER_RECEIVE_ENABLE] <= 1'b0;
      if (mEnd && mst_r == M_ACK) con_r[C_ACKS] <= 1'b0;
      if (mAbort) con_r[4:0] <= 5'h00;
      // Slave transmit start and receive end stretch
      if (sAckClk && sst_r == SL_ADDR && sAdrHit && sSh_r[0]) con_r[C_REL] <= 1'b0;
      if (sAckClk && sst_r == SL_TX && !ln.sdaLvl) con_r[C_REL] <= 1'b0;
      if (sEnd8 && sst_r == SL_RX && con_r[C_STR]) con_r[C_REL] <= 1'b0;
    end
  end
  // ---------------------------------------------
  // Rate generator
  // ---------------------------------------------
  // Half instruction rate enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) halfEn_r <= 1'b0;
    else halfEn_r <= !halfEn_r;
  end
  assign rateTick = halfEn_r && rateCnt_r == 16'h0000;
  // Down counter reloaded at zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rateCnt_r <= BRG_RST;
    else if (mst_r == M_IDLE) rateCnt_r <= rateReload_r;
    else if (halfEn_r)
      rateCnt_r <= (rateCnt_r == 16'h0000) ? rateReload_r : rateCnt_r - 16'h0001;
  end
  // ---------------------------------------------
  // Master sequencer
  // ---------------------------------------------
  assign busy = tbf_r || mst_r != M_IDLE || (sst_r == SL_TX && sCnt_r < BYTE_BITS);
  assign txGo = tbf_r && mOwn_r && con_r[4:0] == 5'h00 && mst_r == M_IDLE;
  // Bit put on data line; released during ack and receive
  assign mBit = (mst_r == M_RX || (mst_r == M_TX && mCnt_r == BYTE_BITS)) ? 1'b1 : mSh_r[7];
  // Last phase of each step
  always_comb begin
    mEnd = 1'b0;
    mAbort = 1'b0;
    if (rateTick) begin
      unique case (mst_r)
        M_IDLE: mEnd = 1'b0;
        M_START: begin
          mEnd = ph_r == 2'd1;
          mAbort = ph_r == 2'd0 && !(ln.sdaLvl && ln.sclLvl);
        end
        M_RESTART: mEnd = ph_r == 2'd3;
        M_STOP: mEnd = ph_r == 2'd2;
        M_TX, M_RX, M_ACK: begin
          mEnd = ph_r == 2'd2 && ln.sclLvl &&
                 mCnt_r == ((mst_r == M_TX) ? BYTE_BITS : (mst_r == M_RX) ? 4'd7 : 4'd0);
          // Released a one but line reads low: lost arbitration
          mAbort = ph_r == 2'd2 && ln.sclLvl && mBit && !ln.sdaLvl &&
                   mst_r != M_RX && !(mst_r == M_TX && mCnt_r == BYTE_BITS);
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mst_r <= M_IDLE;
      ph_r <= 2'd0;
      mCnt_r <= 4'd0;
      mSh_r <= 8'h00;
      mScl_r <= 1'b0;
      mSda_r <= 1'b0;
    end else if (!moduleOn || mAbort) begin
      mst_r <= M_IDLE;
      mScl_r <= 1'b0;
      mSda_r <= 1'b0;
    end else if (mst_r == M_IDLE) begin
      ph_r <= 2'd0;
      mCnt_r <= 4'd0;
      if (con_r[C_STRT]) mst_r <= M_START;
      else if (con_r[C_RSTR]) mst_r <= M_RESTART;
      else if (con_r[C_STOP]) mst_r <= M_STOP;
      else if (con_r[C_MASTER_RECEIVE_ENABLE]) begin
        mst_r <= M_RX;
        mSh_r <= 8'hFF;
      end else if (con_r[C_ACKS]) begin
        mst_r <= M_ACK;
        mSh_r <= {con_r[C_ACKV], 7'h00};
      end else if (txGo) begin
        mst_r <= M_TX;
        mSh_r <= txHold_r;
      end
    end else if (rateTick) begin
      ph_r <= ph_r + 2'd1;
      unique case (mst_r)
        M_START: if (ph_r == 2'd0) mSda_r <= 1'b1;
          else mScl_r <= 1'b1;
        M_RESTART: begin
          if (ph_r == 2'd0) mSda_r <= 1'b0;
          if (ph_r == 2'd1) mScl_r <= 1'b0;
          if (ph_r == 2'd2) mSda_r <= 1'b1;
          if (ph_r == 2'd3) mScl_r <= 1'b1;
        end
        M_STOP: begin
          if (ph_r == 2'd0) mSda_r <= 1'b1;
          if (ph_r == 2'd1) mScl_r <= 1'b0;
          if (ph_r == 2'd2) mSda_r <= 1'b0;
        end
        default: begin
          // Data set, clock freed, then sampled once high
          if (ph_r == 2'd0) mSda_r <= !mBit;
          if (ph_r == 2'd1) mScl_r <= 1'b0;
          if (ph_r == 2'd2) begin
            if (!ln.sclLvl) ph_r <= 2'd2; // Wait while stretched
            else begin
              ph_r <= 2'd0;
              mScl_r <= 1'b1;
              mSh_r <= {mSh_r[6:0], ln.sdaLvl};
              mCnt_r <= mCnt_r + 4'd1;
            end
          end
        end
      endcase
      if (mEnd) begin
        mst_r <= M_IDLE;
        if (mst_r != M_RESTART && mst_r != M_START) mSda_r <= 1'b0;
      end
    end
  end
  // ---------------------------------------------
  // Slave sequencer
  // ---------------------------------------------
  assign sEnd8 = ln.sclFall && sCnt_r == BYTE_BITS;
  assign sAckClk = ln.sclFall && sCnt_r == 4'd9;
  assign sGc = con_r[C_GENERAL_CALL_ENABLE] && sSh_r == 8'h00;
  // Address decision for first and second address bytes
  always_comb begin
    sAdrHit = 1'b0;
    if (sst_r == SL_ADDR) begin
      if (con_r[C_ALL] || sGc) sAdrHit = 1'b1;
      else if (con_r[C_TEN])
        sAdrHit = sSh_r[7:3] == TEN_HDR &&
                  addrMatch({sSh_r[2:1], 8'h00}, {own_r[9:8], 8'h00}, mask_r) &&
                  (!sSh_r[0] || tenArm_r);
      else sAdrHit = addrMatch({3'b000, sSh_r[7:1]}, {3'b000, own_r[6:0]}, mask_r);
    end else if (sst_r == SL_ADDR2) begin
      sAdrHit = addrMatch({2'b00, sSh_r}, {2'b00, own_r[7:0]}, mask_r);
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sst_r <= SL_IDLE;
      sCnt_r <= 4'd0;
      sSh_r <= 8'h00;
      sTx_r <= 8'h00;
      sDrv_r <= 1'b0;
    end else if (!moduleOn || ln.stopDet) begin
      sst_r <= SL_IDLE;
      sDrv_r <= 1'b0;
    end else if (ln.startDet) begin
      sst_r <= SL_ADDR;
      sCnt_r <= 4'd0;
      sDrv_r <= 1'b0;
    end else if (sst_r != SL_IDLE) begin
      if (ln.sclRise && sCnt_r < 4'd9) begin
        sCnt_r <= sCnt_r + 4'd1;
        if (sCnt_r < BYTE_BITS) sSh_r <= {sSh_r[6:0], ln.sdaLvl};
      end
      // Next bit after each fall; data freed after the eighth for the answer
      if (ln.sclFall && sst_r == SL_TX && sCnt_r <= BYTE_BITS) begin
        sTx_r <= {sTx_r[6:0], 1'b1};
        sDrv_r <= (sCnt_r == BYTE_BITS) ? 1'b0 : !sTx_r[6];
      end
      if (sEnd8 && sst_r != SL_TX) begin
        // Acknowledge a matched address or accepted data
        unique case (sst_r)
          SL_ADDR, SL_ADDR2: sDrv_r <= sAdrHit;
          SL_RX: sDrv_r <= !rbf_r;
          default: sDrv_r <= 1'b0;
        endcase
      end
      if (sAckClk) begin
        sCnt_r <= 4'd0;
        sDrv_r <= 1'b0;
        unique case (sst_r)
          SL_ADDR: begin
            if (!sAdrHit) sst_r <= SL_SKIP;
            else if (sSh_r[0] && !sGc) sst_r <= SL_TX;
            else if (con_r[C_TEN] && !con_r[C_ALL] && !sGc) sst_r <= SL_ADDR2;
            else sst_r <= SL_RX;
          end
          SL_ADDR2: sst_r <= sAdrHit ? SL_RX : SL_SKIP;
          SL_TX: if (ln.sdaLvl) sst_r <= SL_SKIP; // Master answered NACK
          default: sst_r <= sst_r;
        endcase
        // Load next outgoing byte
        if ((sst_r == SL_ADDR && sAdrHit && sSh_r[0]) || (sst_r == SL_TX && !ln.sdaLvl)) begin
          sTx_r <= txHold_r;
          sDrv_r <= !txHold_r[7];
        end
      end
    end
  end
  // ---------------------------------------------
  // Receive path
  // ---------------------------------------------
  assign rxLoad = (mEnd && mst_r == M_RX) ||
                  (sEnd8 && (sst_r == SL_RX || ((sst_r == SL_ADDR || sst_r == SL_ADDR2) && sAdrHit)));
  assign rxData = (mst_r == M_RX) ? {mSh_r[6:0], ln.sdaLvl} : sSh_r;
  // Holding register, full and overflow flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxHold_r <= 8'h00;
      rbf_r <= 1'b0;
      ov_r <= 1'b0;
      byteEvent <= 1'b0;
    end else begin
      byteEvent <= rxLoad || (sEnd8 && sst_r == SL_ADDR && sGc);
      if (accRd && sel == 3'h4) rbf_r <= 1'b0;
      if (accWr && sel == 3'h2 && !pwdata[S_OV]) ov_r <= 1'b0;
      // A read in the same cycle frees the holding register; the set wins
      if (rxLoad && rbf_r && !(accRd && sel == 3'h4)) ov_r <= 1'b1;
      else if (rxLoad) begin
        rxHold_r <= rxData;
        rbf_r <= 1'b1;
      end
    end
  end
  // ---------------------------------------------
  // Transmit holding and master flags
  // ---------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txHold_r <= 8'h00;
      tbf_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
    end else begin
      if (accWr && sel == 3'h2 && !pwdata[S_WRITE_COLLISION_FLAG]) write_collision_flag_r <= 1'b0;
      if (accWr && sel == 3'h5) begin
        if (busy) write_collision_flag_r <= 1'b1;
        else begin
          txHold_r <= pwdata[7:0];
          tbf_r <= 1'b1;
        end
      end
      if ((mEnd && mst_r == M_TX) || (sAckClk && sst_r == SL_TX)) tbf_r <= 1'b0;
      if (mAbort) tbf_r <= 1'b0;
    end
  end
  // Transmit status, acknowledge, collision, bus ownership
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trSt_r <= 1'b0;
      ackSt_r <= 1'b0;
      bcl_r <= 1'b0;
      mOwn_r <= 1'b0;
    end else begin
      if (txGo) trSt_r <= 1'b1;
      if ((mEnd && mst_r == M_TX) || mAbort) trSt_r <= 1'b0;
      if (mEnd && mst_r == M_TX) ackSt_r <= ln.sdaLvl;
      if (accWr && sel == 3'h2 && !pwdata[S_BCL]) bcl_r <= 1'b0;
      if (mAbort) bcl_r <= 1'b1;
      if (mEnd && (mst_r == M_START || mst_r == M_RESTART)) mOwn_r <= 1'b1;
      if ((mEnd && mst_r == M_STOP) || mAbort || !moduleOn) mOwn_r <= 1'b0;
    end
  end
  // ---------------------------------------------
  // Slave status flags
  // ---------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gc_r <= 1'b0;
      ten_r <= 1'b0;
      tenArm_r <= 1'b0;
      da_r <= 1'b0;
      rw_r <= 1'b0;
      pSeen_r <= 1'b0;
      sSeen_r <= 1'b0;
    end else begin
      if (ln.startDet) begin
        sSeen_r <= 1'b1;
        pSeen_r <= 1'b0;
      end
      if (ln.stopDet) begin
        pSeen_r <= 1'b1;
        sSeen_r <= 1'b0;
        gc_r <= 1'b0;
        ten_r <= 1'b0;
        tenArm_r <= 1'b0;
      end
      if (sEnd8 && sAdrHit) begin
        da_r <= 1'b0;
        if (sst_r == SL_ADDR) rw_r <= sSh_r[0] && !sGc;
        if (sst_r == SL_ADDR && sGc) gc_r <= 1'b1;
        if (sst_r == SL_ADDR2) begin
          ten_r <= 1'b1;
          tenArm_r <= 1'b1;
        end
      end
      if (sEnd8 && sst_r == SL_RX) da_r <= 1'b1;
    end
  end
  // ---------------------------------------------
  // Pin drivers, all from flip-flops
  // ---------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
      pinsOwned <= 1'b0;
      lineLow_r <= 1'b0;
    end else begin
      pinsOwned <= moduleOn;
      lineLow_r <= 1'b0;
      sdaOe <= moduleOn && (mSda_r || sDrv_r);
      // Slave holds clock while release bit is low
      sclOe <= moduleOn && (mScl_r ||
               ((sst_r == SL_RX || sst_r == SL_TX) && !con_r[C_REL] && !ln.sclLvl));
    end
  end
  assign sclOut = lineLow_r;
  assign sdaOut = lineLow_r;
endmodule // tw_port
`default_nettype wire

// ===== tw_port_props.sv
// Purpose: Port checks for tw_port
// Assumes: APB answer two edges after setup
// Notes: Bound into every tw_port
`default_nettype none
module tw_port_props import tw_pkg::*; #(parameter int AW = 8) (
  input wire logic clk, resetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe, pinsOwned, byteEvent
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_owned_follows: assert property (psel && penable && pready && pwrite && paddr == OFS_CON
    |=> ##1 pinsOwned == $past(pwdata[C_ON], 2)) else $error("enable not mirrored");
  a_pins_free: assert property (!pinsOwned [*2] |-> !sclOe && !sdaOe)
    else $error("pins driven while off");
  a_drive_low: assert property (!sclOut && !sdaOut) else $error("line driven high");
  a_ready_time: assert property (psel && !penable |-> ##2 pready) else $error("late answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_event_pulse: assert property (byteEvent |=> !byteEvent) else $error("event too long");
  a_start_clock: assert property ($rose(sdaOe) && !sclOe && sclIn |-> ##[1:40] sclOe)
    else $error("start without clock low");
  cover property (pslverr);
  cover property (byteEvent);
  cover property ($rose(sclOe));
endmodule // tw_port_props
bind tw_port tw_port_props #(.AW(AW)) u_props (.*);
`default_nettype wire

// ===== tw_bus_peer.sv
// Purpose: Far-side slave on the two-wire bus
// Assumes: Pull-ups on both lines
// Notes: Acks only the byte right after a start
`default_nettype none
module tw_bus_peer (
  input wire logic sclOe, sdaOe, jam,
  output logic sclLine, sdaLine,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ackDrv = 1'b0; // Pulls data low for acknowledge
  logic first = 1'b0; // Next byte is the address
  int cnt = 0;
  assign sclLine = !sclOe;
  assign sdaLine = !(sdaOe || ackDrv || jam);
  always @(negedge sdaLine) if (sclLine) begin cnt = 0; first = 1'b1; end
  always @(posedge sclLine) begin cnt++; if (cnt <= 8) rxByte = {rxByte[6:0], sdaLine}; end
  always @(negedge sclLine) begin
    ackDrv = first && cnt == 8;
    if (cnt == 9) begin cnt = 0; first = 1'b0; end
  end
endmodule // tw_bus_peer
`default_nettype wire

// ===== test_two_wire_master_slave_port.sv
// Purpose: Self-checking bench for the two-wire port
// Assumes: Reload 3 gives a 400 ns bus tick
// Notes: Peer jams data for the collision case
`default_nettype none
module test_two_wire_master_slave_port;
  import tw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, jam = 1'b0;
  logic [7:0] paddr = 8'h00, rxByte;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, err, sclOe, sdaOe, sclLine, sdaLine, pinsOwned, byteEvent;
  int errors = 0, cmp_count = 0, cyc = 0, evts = 0;
  typedef struct {logic [7:0] a; logic [31:0] d, e;} tw_row_t;
  tw_row_t rows [6] = '{'{OFS_MSK, 32'hFFFF_FD55, 32'h0000_0155},
    '{OFS_ADD, 32'h0000_03FF, 32'h0000_03FF}, '{OFS_BRG, 32'h0000_0003, 32'h0000_0003},
    '{OFS_CON, 32'h0000_0C80, 32'h0000_1C80}, '{OFS_CON, 32'h0000_0040, 32'h0000_1040},
    '{OFS_CON, 32'h0000_0040, 32'h0000_0040}};
  tw_port #(.AW(8)) DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(sclLine), .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine),
    .sdaOut(), .sdaOe(sdaOe), .pinsOwned(pinsOwned), .byteEvent(byteEvent));
  tw_bus_peer peer (.sclOe(sclOe), .sdaOe(sdaOe), .jam(jam), .sclLine(sclLine),
    .sdaLine(sdaLine), .rxByte(rxByte));
  always #25 clk = ~clk;
  task automatic report_and_stop();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 20000) begin errors++; report_and_stop(); end
  // Count one-cycle byte event pulses
  always @(posedge clk) if (byteEvent === 1'b1) evts++;
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin errors++; $display("Error %s exp %h got %h", n, e, g); end
  endtask
  // APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  // Poll control until a request bit self-clears
  task automatic waitclr(input int b);
    do apb(1'b0, OFS_CON, 0); while (q[b] !== 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    apb(0, OFS_CON, 0); chk("con reset", q, 32'h0000_1000);
    apb(0, OFS_STAT, 0); chk("stat reset", q, 32'h0000_0000);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 0); chk("reg", q, rows[i].e);
    end
    apb(0, 8'h1C, 0); chk("unmapped", {err, q[30:0]}, 32'h8000_0000);
    jam <= 1'b1;
    apb(1, OFS_CON, 32'h0000_9001); waitclr(C_STRT);
    jam <= 1'b0;
    apb(0, OFS_STAT, 0); chk("collision", q[S_BCL], 1);
    apb(1, OFS_STAT, 0); apb(0, OFS_STAT, 0); chk("bcl clear", q[S_BCL], 0);
    apb(1, OFS_CON, 32'h0000_9001); waitclr(C_STRT);
    apb(0, OFS_STAT, 0); chk("start seen", q[4:3], 2'b01);
    chk("owned", pinsOwned, 1);
    apb(1, OFS_TRN, 32'h0000_00A5); apb(1, OFS_TRN, 32'h0000_005A);
    apb(0, OFS_STAT, 0); chk("busy", {q[S_TRST], q[S_WRITE_COLLISION_FLAG]}, 2'b11);
    do apb(0, OFS_STAT, 0); while (q[S_TRST] !== 1'b0);
    chk("sent", rxByte, 8'hA5);
    chk("acked", {q[S_ACKST], q[0]}, 2'b00);
    apb(1, OFS_CON, 32'h0000_9008); waitclr(C_MASTER_RECEIVE_ENABLE);
    apb(0, OFS_STAT, 0); chk("rx full", q[1], 1);
    chk("events", evts, 1);
    apb(1, OFS_CON, 32'h0000_9030); waitclr(C_ACKS);
    apb(0, OFS_RCV, 0); chk("rx byte", q, 32'h0000_00FF);
    apb(0, OFS_STAT, 0); chk("rx read", q[1], 0);
    apb(1, OFS_CON, 32'h0000_9004); waitclr(C_STOP);
    apb(0, OFS_STAT, 0); chk("stop seen", q[4:3], 2'b10);
    report_and_stop();
  end
endmodule // test_two_wire_master_slave_port
`default_nettype wire
